// File: verilog/pdl_pkg.sv
package pdl_pkg;

    // Register offsets
    localparam logic [7:0] PDL_ADDR_CTRL   = 8'h3A;
    localparam logic [7:0] PDL_ADDR_BW     = 8'h3B;
    localparam logic [7:0] PDL_ADDR_MULH   = 8'h3C;
    localparam logic [7:0] PDL_ADDR_MULL   = 8'h3D;
    localparam logic [7:0] PDL_ADDR_REFDIV = 8'h3F;
    localparam logic [7:0] PDL_ADDR_RANGE  = 8'h40;

    // Control register field positions
    localparam int PDL_CTRL_IE_BIT  = 7;
    localparam int PDL_CTRL_FLG_BIT = 6;
    localparam int PDL_CTRL_ON_BIT  = 5;
    localparam int PDL_CTRL_BCS_BIT = 4;
    localparam int PDL_CTRL_PRE_LSB = 2;

    // Bandwidth register field positions
    localparam int PDL_BW_AUTO_BIT  = 7;
    localparam int PDL_BW_LOCK_BIT  = 6;
    localparam int PDL_BW_TRK_BIT   = 5;

    // Values after reset
    localparam logic        PDL_RST_ON     = 1'b1;
    localparam logic [1:0]  PDL_RST_PRE    = 2'h0;
    localparam logic [3:0]  PDL_RST_MULH   = 4'h0;
    localparam logic [7:0]  PDL_RST_MULL   = 8'h02;
    localparam logic [3:0]  PDL_RST_REFDIV = 4'h1;
    localparam logic [7:0]  PDL_RST_RANGE  = 8'h01;

    // Frequency tolerances in core cycles of period difference
    localparam logic [11:0] PDL_TOL_TRK  = 12'h002;
    localparam logic [11:0] PDL_TOL_UNT  = 12'h004;
    localparam logic [11:0] PDL_TOL_LOCK = 12'h001;
    localparam logic [11:0] PDL_TOL_UNL  = 12'h003;

    // Source clock edges waited during a switch
    localparam logic [1:0]  PDL_SW_EDGES = 2'h3;

    typedef enum logic [2:0] {
        PDL_SEL_RUN = 3'h1,
        PDL_SEL_OLD = 3'h2,
        PDL_SEL_NEW = 3'h4
    } pdl_sel_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pdl_bus_req_t;

    typedef struct packed {
        logic       pump_up;
        logic       pump_down;
        logic       tracking_mode;
        logic       loop_enable;
        logic       locked;
    } pdl_loop_ctl_t;

    typedef struct packed {
        logic [2:0]     xs;
        logic [2:0]     vs;
        logic           xlvl;
        logic           vlvl;
        logic           ie;
        logic           flag;
        logic           on;
        logic           base_clock_select;
        logic [1:0]     pre;
        logic           auto_bw;
        logic           lock;
        logic           track;
        logic [3:0]     mulh;
        logic [7:0]     mull;
        logic [3:0]     refdiv;
        logic [7:0]     range;
        logic [11:0]    rdiv_cnt;
        logic [2:0]     pre_cnt;
        logic [11:0]    ndiv_cnt;
        logic [11:0]    rper_cnt;
        logic [11:0]    fper_cnt;
        logic [11:0]    fper;
        pdl_loop_ctl_t  loop;
        pdl_sel_state_t sel;
        logic [1:0]     sw_cnt;
        logic           active;
        logic           base;
        logic           usb;
        logic           irq;
        logic [7:0]     rdata;
    } pdl_state_t;

endpackage

// File: verilog/pdl_core.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
module pdl_core
    import pdl_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic          crystal_clock,
    input  wire logic          vco_clock,
    input  wire pdl_bus_req_t  bus_req,
    output logic [7:0]         bus_rdata,
    output pdl_loop_ctl_t      loop_ctl,
    output logic               base_clock_out,
    output logic               usb_side_clock,
    output logic               settle_irq
);

    pdl_state_t q;
    pdl_state_t s;

    function automatic logic [11:0] pdl_at_least_one(input logic [11:0] v);
        pdl_at_least_one = (v == 12'h000) ? 12'h001 : v;
    endfunction

    function automatic logic [11:0] pdl_abs_diff(input logic [11:0] a, input logic [11:0] b);
        pdl_abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    function automatic logic pdl_edge(input logic [2:0] sy, input logic lvl);
        pdl_edge = (sy[1] == sy[2]) && sy[2] && !lvl;
    endfunction

    always_comb begin
        logic        x_rise;
        logic        v_raw;
        logic        v_rise;
        logic        loop_run;
        logic        ref_tick;
        logic        fb_tick;
        logic        rd_ctrl;
        logic        wr_ctrl;
        logic        old_rise;
        logic        new_rise;
        logic        in_bcs;
        logic        in_on;
        logic [2:0]  pre_max;
        logic [11:0] r_max;
        logic [11:0] n_max;
        logic [11:0] diff;
        s        = q;
        x_rise   = 1'b0;
        v_raw    = 1'b0;
        v_rise   = 1'b0;
        loop_run = 1'b0;
        ref_tick = 1'b0;
        fb_tick  = 1'b0;
        rd_ctrl  = 1'b0;
        wr_ctrl  = 1'b0;
        old_rise = 1'b0;
        new_rise = 1'b0;
        in_bcs   = 1'b0;
        in_on    = 1'b0;
        pre_max  = 3'h0;
        r_max    = 12'h000;
        n_max    = 12'h000;
        diff     = 12'h000;

        // Pin synchronisers; level moves once last two stages agree
        s.xs = {q.xs[1:0], crystal_clock};
        s.vs = {q.vs[1:0], vco_clock};
        x_rise = pdl_edge(q.xs, q.xlvl);
        v_raw  = pdl_edge(q.vs, q.vlvl);
        if (q.xs[1] == q.xs[2]) begin
            s.xlvl = q.xs[2];
        end
        if (q.vs[1] == q.vs[2]) begin
            s.vlvl = q.vs[2];
        end

        loop_run = q.on && (q.range != 8'h00);
        v_rise   = v_raw && loop_run;

        // Register writes
        rd_ctrl = bus_req.rd && (bus_req.addr == PDL_ADDR_CTRL);
        wr_ctrl = bus_req.wr && (bus_req.addr == PDL_ADDR_CTRL);
        if (wr_ctrl) begin
            in_bcs = bus_req.wdata[PDL_CTRL_BCS_BIT];
            in_on  = bus_req.wdata[PDL_CTRL_ON_BIT];
            s.ie   = q.auto_bw && bus_req.wdata[PDL_CTRL_IE_BIT];
            if (!q.on) begin
                s.pre = bus_req.wdata[PDL_CTRL_PRE_LSB +: 2];
            end
            if (in_bcs != q.base_clock_select) begin
                // Select change wins; power bit held this write
                s.base_clock_select = in_bcs && loop_run;
            end else if (!q.base_clock_select) begin
                s.on = in_on;
            end
        end
        if (bus_req.wr) begin
            case (bus_req.addr)
                PDL_ADDR_BW: begin
                    s.auto_bw = bus_req.wdata[PDL_BW_AUTO_BIT];
                    if (!q.auto_bw) begin
                        s.track = bus_req.wdata[PDL_BW_TRK_BIT];
                    end
                end
                PDL_ADDR_MULH: begin
                    s.mulh = bus_req.wdata[3:0];
                end
                PDL_ADDR_MULL: begin
                    s.mull = bus_req.wdata;
                end
                PDL_ADDR_REFDIV: begin
                    s.refdiv = bus_req.wdata[3:0];
                end
                PDL_ADDR_RANGE: begin
                    s.range = bus_req.wdata;
                end
                default: begin
                end
            endcase
        end
        if (!s.auto_bw) begin
            s.ie = 1'b0;
        end
        if (s.range == 8'h00) begin
            s.base_clock_select = 1'b0;
        end

        // Reference divider
        r_max = pdl_at_least_one({8'h00, q.refdiv}) - 12'h001;
        if (x_rise && loop_run) begin
            if (q.rdiv_cnt >= r_max) begin
                s.rdiv_cnt = 12'h000;
                ref_tick   = 1'b1;
            end else begin
                s.rdiv_cnt = q.rdiv_cnt + 12'h001;
            end
        end

        // Feedback prescaler and modulo divider
        case (q.pre)
            2'h0:    pre_max = 3'h0;
            2'h1:    pre_max = 3'h1;
            2'h2:    pre_max = 3'h3;
            default: pre_max = 3'h7;
        endcase
        n_max = pdl_at_least_one({q.mulh, q.mull}) - 12'h001;
        if (v_rise) begin
            if (q.pre_cnt >= pre_max) begin
                s.pre_cnt = 3'h0;
                if (q.ndiv_cnt >= n_max) begin
                    s.ndiv_cnt = 12'h000;
                    fb_tick    = 1'b1;
                end else begin
                    s.ndiv_cnt = q.ndiv_cnt + 12'h001;
                end
            end else begin
                s.pre_cnt = q.pre_cnt + 3'h1;
            end
        end

        // Phase detector: first edge opens a pulse, the other closes it
        if (!loop_run || (ref_tick && fb_tick)) begin
            s.loop.pump_up   = 1'b0;
            s.loop.pump_down = 1'b0;
        end else if (ref_tick) begin
            if (q.loop.pump_down) begin
                s.loop.pump_down = 1'b0;
            end else begin
                s.loop.pump_up = 1'b1;
            end
        end else if (fb_tick) begin
            if (q.loop.pump_up) begin
                s.loop.pump_up = 1'b0;
            end else begin
                s.loop.pump_down = 1'b1;
            end
        end

        // Period measurement in core cycles, saturating
        if (q.rper_cnt != 12'hFFF) begin
            s.rper_cnt = q.rper_cnt + 12'h001;
        end
        if (q.fper_cnt != 12'hFFF) begin
            s.fper_cnt = q.fper_cnt + 12'h001;
        end
        if (fb_tick) begin
            s.fper     = q.fper_cnt;
            s.fper_cnt = 12'h000;
        end

        // Frequency comparison once per divided reference period
        diff = pdl_abs_diff(q.rper_cnt, q.fper);
        if (ref_tick) begin
            s.rper_cnt = 12'h000;
        end
        if (!loop_run || !s.auto_bw) begin
            s.lock = 1'b0;
            if (s.auto_bw) begin
                s.track = 1'b0;
            end
        end else if (ref_tick) begin
            if (diff <= PDL_TOL_TRK) begin
                s.track = 1'b1;
            end else if (diff > PDL_TOL_UNT) begin
                s.track = 1'b0;
            end
            if (diff <= PDL_TOL_LOCK) begin
                s.lock = 1'b1;
            end else if (diff > PDL_TOL_UNL) begin
                s.lock = 1'b0;
            end
        end

        // Change flag: toggle beats a clearing read
        if (!s.auto_bw) begin
            s.flag = 1'b0;
        end else begin
            s.flag = (q.flag && !rd_ctrl) || (s.lock != q.lock);
        end
        s.irq = s.flag && s.ie;

        s.loop.tracking_mode = s.track;
        s.loop.loop_enable   = s.on && (s.range != 8'h00);
        s.loop.locked        = s.lock;

        // Base clock selector
        old_rise = q.active ? v_rise : x_rise;
        new_rise = s.active ? v_rise : x_rise;
        case (q.sel)
            PDL_SEL_RUN: begin
                if (q.base_clock_select != q.active) begin
                    s.sel    = PDL_SEL_OLD;
                    s.sw_cnt = 2'h0;
                end else if (new_rise) begin
                    s.base = !q.base;
                end
            end
            PDL_SEL_OLD: begin
                if (old_rise || (q.active && !loop_run)) begin
                    s.sw_cnt = q.sw_cnt + 2'h1;
                    if ((q.sw_cnt + 2'h1) == PDL_SW_EDGES || !loop_run) begin
                        s.sel    = PDL_SEL_NEW;
                        s.sw_cnt = 2'h0;
                        s.active = q.base_clock_select;
                    end
                end
            end
            PDL_SEL_NEW: begin
                if (old_rise) begin
                    s.sw_cnt = q.sw_cnt + 2'h1;
                    if ((q.sw_cnt + 2'h1) == PDL_SW_EDGES) begin
                        s.sel = PDL_SEL_RUN;
                    end
                end
            end
            default: begin
                s.sel = PDL_SEL_RUN;
            end
        endcase
        s.usb = q.active ? q.vlvl : q.xlvl;

        // Read data, valid the cycle after the strobe
        s.rdata = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                PDL_ADDR_CTRL: begin
                    s.rdata = {q.ie, q.flag, q.on, q.base_clock_select, q.pre, 2'h0};
                end
                PDL_ADDR_BW: begin
                    s.rdata = {q.auto_bw, q.lock, q.track, 5'h00};
                end
                PDL_ADDR_MULH: begin
                    s.rdata = {4'h0, q.mulh};
                end
                PDL_ADDR_MULL: begin
                    s.rdata = q.mull;
                end
                PDL_ADDR_REFDIV: begin
                    s.rdata = {4'h0, q.refdiv};
                end
                PDL_ADDR_RANGE: begin
                    s.rdata = q.range;
                end
                default: begin
                    s.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q          <= '0;
            q.on       <= PDL_RST_ON;
            q.pre      <= PDL_RST_PRE;
            q.mulh     <= PDL_RST_MULH;
            q.mull     <= PDL_RST_MULL;
            q.refdiv   <= PDL_RST_REFDIV;
            q.range    <= PDL_RST_RANGE;
            q.sel      <= PDL_SEL_RUN;
            q.loop     <= '0;
            q.rdata    <= 8'h00;
        end else begin
            q <= s;
        end
    end

    assign bus_rdata      = q.rdata;
    assign loop_ctl       = q.loop;
    assign base_clock_out = q.base;
    assign usb_side_clock = q.usb;
    assign settle_irq     = q.irq;

endmodule

// File: verification/pdl_core_asserts.sv
`timescale 1ns/10ps
module pdl_core_asserts
    import pdl_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          reset,
    input wire logic          crystal_clock,
    input wire logic          vco_clock,
    input wire pdl_bus_req_t  bus_req,
    input wire logic [7:0]    bus_rdata,
    input wire pdl_loop_ctl_t loop_ctl,
    input wire logic          base_clock_out,
    input wire logic          usb_side_clock,
    input wire logic          settle_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence ctrl_read;
        bus_req.rd && bus_req.addr == PDL_ADDR_CTRL;
    endsequence

    sequence bw_read;
        bus_req.rd && bus_req.addr == PDL_ADDR_BW;
    endsequence

    chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 8'h3E |=> bus_rdata == 8'h00)
        else $error("unmapped read returned data");
    chk_pump_excl: assert property (!(loop_ctl.pump_up && loop_ctl.pump_down))
        else $error("both pump directions active");
    chk_off_unlocked: assert property (!loop_ctl.loop_enable [*3] |-> !loop_ctl.locked)
        else $error("lock reported with loop disabled");
    chk_lock_tracks: assert property (loop_ctl.locked |-> loop_ctl.tracking_mode)
        else $error("locked while acquiring");
    chk_enable_on: assert property (ctrl_read |=> bus_rdata[PDL_CTRL_ON_BIT] || !$past(loop_ctl.loop_enable))
        else $error("loop enabled with power bit clear");
    chk_bw_status: assert property (bw_read |=> bus_rdata[PDL_BW_LOCK_BIT] == $past(loop_ctl.locked) && bus_rdata[PDL_BW_TRK_BIT] == $past(loop_ctl.tracking_mode))
        else $error("status bits disagree with loop outputs");
    chk_flag_clear: assert property (ctrl_read ##0 $stable(loop_ctl.locked) [*4] |-> !settle_irq)
        else $error("request survives control read");
    chk_base_space: assert property ($changed(base_clock_out) |=> $stable(base_clock_out) [*3])
        else $error("base clock toggles too fast");
endmodule

// File: verification/pdl_sim_model.sv
`timescale 1ns/10ps
module pdl_sim_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        base_clock_out,
    output logic             bus_clock,
    output logic [15:0]      base_edges
);
    logic base_seen;

    // Bus clock is base clock halved, a quarter of the source
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            base_seen  <= 1'b0;
            bus_clock  <= 1'b0;
            base_edges <= 16'h0000;
        end else begin
            base_seen <= base_clock_out;
            if (base_seen != base_clock_out) begin
                base_edges <= base_edges + 16'h0001;
                if (base_clock_out) begin
                    bus_clock <= !bus_clock;
                end
            end
        end
    end
endmodule

// File: verification/tb.sv
`timescale 1ns/10ps
module tb;
    import pdl_pkg::*;
    logic          core_clk = 1'b0;
    logic          reset = 1'b1;
    logic          crystal_clock = 1'b0;
    logic          vco_clock = 1'b0;
    pdl_bus_req_t  bus_req = '0;
    logic [7:0]    bus_rdata;
    pdl_loop_ctl_t loop_ctl;
    logic          base_clock_out;
    logic          usb_side_clock;
    logic          settle_irq;
    logic          bus_clock;
    logic [15:0]   base_edges;
    logic [15:0]   mark_edges;
    int            err_total = 0;
    int            comparisons = 0;
    int            vco_half = 100;
    logic [7:0]    map_a [7] = '{PDL_ADDR_CTRL, PDL_ADDR_BW, PDL_ADDR_MULH, PDL_ADDR_MULL,
                                 PDL_ADDR_REFDIV, PDL_ADDR_RANGE, 8'h3E};
    logic [7:0]    map_v [7] = '{8'h20, 8'h00, 8'h00, 8'h02, 8'h01, 8'h01, 8'h00};

    always #12.5 core_clk = !core_clk;
    always #200 crystal_clock = !crystal_clock;
    always begin
        #(vco_half);
        vco_clock = !vco_clock;
    end

    pdl_core dut_u (.core_clk(core_clk), .reset(reset), .crystal_clock(crystal_clock),
        .vco_clock(vco_clock), .bus_req(bus_req), .bus_rdata(bus_rdata), .loop_ctl(loop_ctl),
        .base_clock_out(base_clock_out), .usb_side_clock(usb_side_clock),
        .settle_irq(settle_irq));

    pdl_sim_model sim_u (.core_clk(core_clk), .reset(reset), .base_clock_out(base_clock_out),
        .bus_clock(bus_clock), .base_edges(base_edges));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_span(input logic [15:0] got, input logic [15:0] lo,
                              input logic [15:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        check8(bus_rdata, exp);
    endtask

    task automatic wait_lock(input logic want);
        int n;
        n = 0;
        while (loop_ctl.locked !== want && n < 4000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (loop_ctl.locked !== want) begin
            err_total++;
            conclude();
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic count_edges(input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] mark;
        #1;
        mark = base_edges;
        repeat (640) @(posedge core_clk);
        #1;
        check_span(base_edges - mark, lo, hi);
    endtask

    task automatic count_usb(input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] n;
        logic        last;
        n = 16'h0000;
        last = usb_side_clock;
        repeat (64) begin
            @(posedge core_clk);
            #1;
            if (usb_side_clock !== last) begin
                n++;
            end
            last = usb_side_clock;
        end
        check_span(n, lo, hi);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            reg_rd(map_a[i], map_v[i]);
        end
        reg_wr(PDL_ADDR_CTRL, 8'hAC);
        reg_rd(PDL_ADDR_CTRL, 8'h20);
        reg_wr(PDL_ADDR_BW, 8'h20);
        reg_rd(PDL_ADDR_BW, 8'h20);
        check8({7'h0, loop_ctl.tracking_mode}, 8'h01);
        reg_wr(PDL_ADDR_BW, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check8({7'h0, loop_ctl.tracking_mode}, 8'h00);
        reg_wr(PDL_ADDR_BW, 8'h80);
        reg_wr(PDL_ADDR_CTRL, 8'hA0);
        wait_lock(1'b1);
        check8({7'h0, settle_irq}, 8'h01);
        reg_rd(PDL_ADDR_BW, 8'hE0);
        reg_rd(PDL_ADDR_CTRL, 8'hE0);
        reg_rd(PDL_ADDR_CTRL, 8'hA0);
        check8({7'h0, settle_irq}, 8'h00);
        // Feedback period 24 cycles against 16
        vco_half = 150;
        wait_lock(1'b0);
        check8({7'h0, settle_irq}, 8'h01);
        repeat (64) @(posedge core_clk);
        reg_rd(PDL_ADDR_BW, 8'h80);
        reg_rd(PDL_ADDR_CTRL, 8'hE0);
        vco_half = 100;
        wait_lock(1'b1);
        reg_rd(PDL_ADDR_CTRL, 8'hE0);
        reg_wr(PDL_ADDR_CTRL, 8'hB0);
        repeat (200) @(posedge core_clk);
        reg_rd(PDL_ADDR_CTRL, 8'hB0);
        count_edges(16'h004E, 16'h0052);
        count_usb(16'h000F, 16'h0011);
        reg_wr(PDL_ADDR_CTRL, 8'h90);
        reg_rd(PDL_ADDR_CTRL, 8'hB0);
        reg_wr(PDL_ADDR_CTRL, 8'h80);
        reg_rd(PDL_ADDR_CTRL, 8'hA0);
        // Base clock frozen while the selector changes over
        mark_edges = base_edges;
        repeat (40) @(posedge core_clk);
        #1;
        check_span(base_edges - mark_edges, 16'h0000, 16'h0000);
        repeat (200) @(posedge core_clk);
        count_edges(16'h0026, 16'h002A);
        count_usb(16'h0007, 16'h0009);
        reg_wr(PDL_ADDR_CTRL, 8'h80);
        // Loop off drops the lock, which raises the change flag
        reg_rd(PDL_ADDR_CTRL, 8'hC0);
        reg_wr(PDL_ADDR_CTRL, 8'h90);
        reg_rd(PDL_ADDR_CTRL, 8'h80);
        reg_wr(PDL_ADDR_CTRL, 8'h8C);
        reg_rd(PDL_ADDR_CTRL, 8'h8C);
        reg_wr(PDL_ADDR_RANGE, 8'h00);
        reg_wr(PDL_ADDR_CTRL, 8'hAC);
        reg_wr(PDL_ADDR_CTRL, 8'hBC);
        reg_rd(PDL_ADDR_CTRL, 8'hAC);
        check8({7'h0, loop_ctl.loop_enable}, 8'h00);
        // Prescale 8, N 2 against R 8: both periods 128 cycles
        reg_wr(PDL_ADDR_REFDIV, 8'h08);
        reg_wr(PDL_ADDR_RANGE, 8'h01);
        wait_lock(1'b1);
        reg_rd(PDL_ADDR_BW, 8'hE0);
        conclude();
    end
endmodule

bind pdl_core pdl_core_asserts chk_u (.core_clk(core_clk), .reset(reset),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .loop_ctl(loop_ctl), .base_clock_out(base_clock_out),
    .usb_side_clock(usb_side_clock), .settle_irq(settle_irq));
